// ---- dv/dual_port_semaphore_flags_bench.sv ----
// Purpose: Self-checking bench for the semaphore port controller
// Assumes: Bench plays the far port controller through the model
// Notes:   Random flag index, fixed seed
`timescale 1ns/1ps

module dual_port_semaphore_flags_bench;
    import sem_host_pkg::*;
    logic clk = 1'b0; // 40 MHz
    logic sys_rst = 1'b1; // Reset
    logic cmd_valid = 1'b0; // Command strobe
    sem_cmd_t cmd = '0; // Command word
    logic cmd_ready, rsp_valid, init_done, dq_oe_n, rd_drv; // Design and model outputs
    sem_rsp_t rsp; // Result
    sem_pins_t pins; // Pins
    logic [DATA_W-1:0] dq_out, rd_q, dq_wire; // Data paths
    logic [DATA_W-1:0] last_dq = 8'h00; // Undriven wire shows the inverse
    logic b_we = 1'b0, b_d = 1'b1; // Port B strobe and value
    logic [IDX_W-1:0] b_idx = 3'h0, k; // Port B index, chosen flag
    logic [7:0] b_flag; // Port B flags
    int miscompares = 0, tests_run = 0, seed = 59377, lat, n; // Counters

    always #12.5 clk = ~clk;
    // Wire level from both drivers; no pull, so floats to the inverse
    assign dq_wire = !dq_oe_n ? dq_out : (rd_drv ? rd_q : ~last_dq);
    always @(posedge clk) last_dq <= dq_wire;

    sem_port_ctrl u_sem_port_ctrl (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .init_done(init_done), .pins(pins),
        .dq_in(dq_wire), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
    sem_dev_model u_sem_dev_model (.clk(clk), .pins(pins), .dq(dq_wire), .rd_q(rd_q), .rd_drv(rd_drv),
        .b_we(b_we), .b_d(b_d), .b_idx(b_idx), .b_flag(b_flag));

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Cycles from take to answer
    function automatic int exp_lat(input sem_op_t op, input logic fail_wd);
        return op == OP_INIT ? 25 : (op == OP_ACQUIRE ? (fail_wd ? 10 : 7) : 4);
    endfunction

    // One command, latency counted from the take edge
    task automatic issue(input sem_op_t op, input logic [IDX_W-1:0] ix, input logic wd, input logic fail);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            #2;
            n++;
        end
        cmd = '{op: op, index: ix, withdraw: wd};
        cmd_valid = 1'b1;
        @(posedge clk);
        #2;
        cmd_valid = 1'b0;
        lat = 0;
        do
        begin
            @(posedge clk);
            #2;
            lat++;
        end while (rsp_valid !== 1'b1 && lat < 40);
        if (n >= 60 || lat >= 40)
        begin
            miscompares++;
            print_verdict();
        end
        // Pulse shows just after the edge before the one that samples it high
        check("latency", 8'(lat + 1), 8'(exp_lat(op, fail && wd)));
        if (op != OP_RELEASE && op != OP_INIT)
            check("spread", rsp.spread_err, 1'b0);
    endtask

    // Far port write, then let arbitration settle
    task automatic bwr(input logic [IDX_W-1:0] ix, input logic v);
        b_idx = ix;
        b_d = v;
        b_we = 1'b1;
        @(posedge clk);
        #2;
        b_we = 1'b0;
        repeat (2) @(posedge clk);
        #2;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        #2;
        sys_rst = 1'b0;
        n = 0;
        while (init_done !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            #2;
            n++;
        end
        check("init_done", init_done, 1'b1);
        // A sweep that never ends goes straight to the report
        if (init_done !== 1'b1)
            print_verdict();
        for (int i = 0; i < 8; i++)
            bwr(3'(i), 1'b1);
        issue(OP_INIT, 3'h0, 1'b0, 1'b0);
        check("all_free", b_flag, 8'hFF);
        repeat (5)
        begin
            k = 3'($random(seed));
            issue(OP_ACQUIRE, k, 1'b0, 1'b0);
            check("granted", rsp.granted, 1'b1);
            check("b_side", b_flag[k], 1'b1);
            bwr(k, 1'b0);
            issue(OP_POLL, k, 1'b0, 1'b0);
            check("a_keeps", rsp.flag, 1'b0);
            issue(OP_RELEASE, k, 1'b0, 1'b0);
            repeat (2) @(posedge clk);
            #2;
            check("b_takes", b_flag, ~(8'h01 << k));
            issue(OP_ACQUIRE, k, 1'b0, 1'b1);
            check("fail", {rsp.granted, rsp.flag}, 8'h01);
            bwr(k, 1'b1);
            issue(OP_POLL, k, 1'b0, 1'b0);
            check("a_pend_win", rsp.flag, 1'b0);
            issue(OP_RELEASE, k, 1'b0, 1'b0);
            bwr(k, 1'b0);
            check("b_free_take", b_flag[k], 1'b0);
            issue(OP_ACQUIRE, k, 1'b1, 1'b1);
            check("withdraw", {rsp.granted, rsp.flag}, 8'h01);
            bwr(k, 1'b1);
            issue(OP_POLL, k, 1'b0, 1'b0);
            check("left_free", rsp.flag, 1'b1);
            check("b_all_free", b_flag, 8'hFF);
        end
        print_verdict();
    end
endmodule // dual_port_semaphore_flags_bench

// ---- dv/sem_dev_model.sv ----
// Purpose: Behavioural two-port semaphore device, port A on pins, port B direct
// Assumes: Pins sampled on clk; flags come up requested, not free
// Notes:   Owner code 0 free, 1 port A, 2 port B
`timescale 1ns/1ps

module sem_dev_model
    import sem_host_pkg::*;
(
    input wire logic clk, // Sampling clock
    input wire sem_pins_t pins, // Port A pins
    input wire logic [DATA_W-1:0] dq, // Port A data wire
    output logic [DATA_W-1:0] rd_q, // Port A read latch
    output logic rd_drv, // Port A drives data
    input wire logic b_we, // Port B write strobe
    input wire logic b_d, // Port B write value
    input wire logic [IDX_W-1:0] b_idx, // Port B flag index
    output logic [7:0] b_flag // Flags as port B reads them
);
    logic [7:0] req_a = 8'h00; // No init at power-up, so stale requests
    logic [7:0] req_b = 8'h00; // Same on the far side
    logic [1:0] own [0:7] = '{default: 2'h0}; // Owner per flag, latches apart from array
    logic rd_prev = 1'b0; // Read active last cycle

    // Port A read active only with array select off
    assign rd_drv = !pins.sem_n && pins.ce_n && !pins.oe_n && pins.rw_n;

    // Request latches, arbitration and read capture
    always @(posedge clk)
    begin
        if (!pins.sem_n && pins.ce_n && !pins.rw_n)
            req_a[pins.addr] <= dq[0];
        if (b_we)
            req_b[b_idx] <= b_d;
        for (int i = 0; i < 8; i++)
        begin
            case (own[i])
                2'h0: own[i] <= !req_a[i] ? 2'h1 : (!req_b[i] ? 2'h2 : 2'h0);
                2'h1: if (req_a[i]) own[i] <= req_b[i] ? 2'h0 : 2'h2;
                default: if (req_b[i]) own[i] <= req_a[i] ? 2'h0 : 2'h1;
            endcase
        end
        rd_prev <= rd_drv;
        if (rd_drv && !rd_prev)
            rd_q <= {DATA_W{own[pins.addr] != 2'h1}};
    end

    // Port B view of each flag
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            b_flag[i] = own[i] != 2'h2;
    end
endmodule // sem_dev_model

// ---- dv/sem_port_chk.sv ----
// Purpose: Concurrent checks on the semaphore port controller pins
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every instance of the controller
`timescale 1ns/1ps

module sem_port_chk
    import sem_host_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic cmd_valid, // Command offered
    input wire sem_cmd_t cmd, // Command word
    input wire logic cmd_ready, // Command taken when high
    input wire logic rsp_valid, // Result strobe
    input wire sem_rsp_t rsp, // Result
    input wire logic init_done, // Sweep over
    input wire sem_pins_t pins, // Device pins
    input wire logic [DATA_W-1:0] dq_in, // Data from device
    input wire logic [DATA_W-1:0] dq_out, // Data to device
    input wire logic dq_oe_n // Drive enable, low active
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic take; // Command handshake
    assign take = cmd_valid && cmd_ready;

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    ce_high_a: assert property (pins.ce_n) else $error("array select went active");
    ready_drop_a: assert property (take |=> !cmd_ready) else $error("ready stayed up after take");
    rsp_pulse_a: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid) else $error("bad result pulse");
    release_lat_a: assert property (take && cmd.op == OP_RELEASE |-> ##4 rsp_valid && rsp.flag)
        else $error("release answer late or wrong");
    acq_write_a: assert property (take && cmd.op == OP_ACQUIRE |=> !pins.sem_n && !pins.rw_n && !dq_oe_n
        && !dq_out[0]) else $error("acquire did not start with zero write");
    read_gap_a: assert property ($rose(pins.oe_n) |=> pins.oe_n) else $error("read strobe gap too short");
    no_contend_a: assert property (!pins.oe_n |-> dq_oe_n && pins.rw_n) else $error("drive during read");
    wr_width_a: assert property ($fell(pins.rw_n) |-> (!pins.sem_n && !pins.rw_n) [*2])
        else $error("write strobe too short");
    poll_lat_a: assert property (take && cmd.op == OP_POLL |-> ##4 rsp_valid) else $error("poll late");
    init_ready_a: assert property ($rose(init_done) |-> cmd_ready && !rsp_valid)
        else $error("ready not with sweep end");
endmodule // sem_port_chk

bind sem_port_ctrl sem_port_chk u_sem_port_chk (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .init_done(init_done),
    .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

// ---- rtl/sem_host_pkg.sv ----
// Purpose: Shared types and constants for the semaphore port controller
// Assumes: One port of a dual-port semaphore device, driven at 40 MHz
// Notes:   Strobe widths are conservative cycle counts derived from ns figures

package sem_host_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25; // 40 MHz system clock
    localparam int WR_PULSE_NS = 50; // Semaphore write strobe width
    localparam int RD_ACCESS_NS = 50; // Read access before sampling
    localparam int GAP_NS = 25; // Select inactive time between accesses

    // Least time to whole cycles, never below one
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CNT_W = 4; // Width of the strobe counter
    localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(min_cycles(WR_PULSE_NS));
    localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(min_cycles(RD_ACCESS_NS));
    localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'(min_cycles(GAP_NS));

    // ---------------------------------------------------------------
    // Field widths and values
    // ---------------------------------------------------------------
    localparam int DATA_W = 8; // Port data width
    localparam int IDX_W = 3; // Flag index width
    localparam logic [IDX_W-1:0] LAST_IDX = 3'h7; // Eighth flag
    localparam logic [IDX_W-1:0] FIRST_IDX = 3'h0; // First flag
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00; // All lines low
    localparam logic [DATA_W-1:0] DATA_ONES = 8'hFF; // All lines high
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0; // Counter expired

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {OP_INIT, OP_ACQUIRE, OP_RELEASE, OP_POLL} sem_op_t;

    typedef struct packed {
        sem_op_t op; // Requested operation
        logic [IDX_W-1:0] index; // Target flag
        logic withdraw; // Acquire: write one back on failure
    } sem_cmd_t;

    typedef struct packed {
        logic granted; // Acquire read back zero
        logic flag; // Flag level as read on this port
        logic spread_err; // Data lines disagreed on read
    } sem_rsp_t;

    typedef struct packed {
        logic ce_n; // Array select, held inactive
        logic sem_n; // Semaphore space select, active low
        logic oe_n; // Output enable, active low
        logic rw_n; // High read, low write
        logic [IDX_W-1:0] addr; // Flag index lines
    } sem_pins_t;

    localparam sem_pins_t PINS_IDLE = '{ce_n: 1'b1, sem_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1, addr: 3'h0};

    typedef enum logic [2:0] {S_BOOT, S_IDLE, S_WRITE, S_WGAP, S_READ, S_RGAP} sem_state_t;

endpackage

// ---- rtl/sem_port_ctrl.sv ----
// Purpose: Drives one port of a dual-port semaphore device from a command port
// Assumes: Pin inputs synchronous to clk; the far port is another controller
// Notes:   Frees all eight flags after reset; acquire is write-zero-then-read
//
// Contract
// - Zero requests token, same port writes one
// - Semaphore select low, then plain SRAM access
// - Deassert select or enable between polls
// - Acquire by write zero then read back
// - After failure reread or withdraw with one
// - Write one to all eight at start-up
// - Array select inactive during semaphore access

`timescale 1ns/1ps

module sem_port_ctrl
    import sem_host_pkg::*;
(
    input wire logic clk, // 40 MHz clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic cmd_valid, // Command offered
    input wire sem_cmd_t cmd, // Command word
    output logic cmd_ready, // Controller can take a command
    output logic rsp_valid, // One-cycle result strobe
    output sem_rsp_t rsp, // Result of last command
    output logic init_done, // Start-up flag freeing finished
    output sem_pins_t pins, // Select, strobe and index pins
    input wire logic [DATA_W-1:0] dq_in, // Data lines as seen on the pins
    output logic [DATA_W-1:0] dq_out, // Data driven onto the pins
    output logic dq_oe_n // Low while this port drives data
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    sem_state_t state_reg; // Sequencer state
    sem_op_t op_reg; // Operation in progress
    logic [IDX_W-1:0] idx_reg; // Flag being accessed
    logic withdraw_reg; // Withdraw requested on failure
    logic read_done_reg; // Acquire has already read back
    logic boot_reg; // Start-up sequence, no response
    logic [CNT_W-1:0] cnt_reg; // Strobe width counter
    logic [DATA_W-1:0] rd_data_reg; // Data captured on read
    logic cmd_ready_reg; // Registered ready
    logic rsp_valid_reg; // Registered result strobe
    sem_rsp_t rsp_reg; // Registered result
    logic init_done_reg; // Registered start-up status
    sem_pins_t pins_reg; // Registered pins
    logic [DATA_W-1:0] dq_out_reg; // Registered data
    logic dq_oe_n_reg; // Registered data enable

    // Spread check on a read; a clean read has all lines equal
    function automatic logic spread_bad(input logic [DATA_W-1:0] d);
        return (d != DATA_ZERO) && (d != DATA_ONES);
    endfunction

    // ---------------------------------------------------------------
    // Access sequencer and pin drivers
    // ---------------------------------------------------------------
    // Pins and state move together so every pin comes from a flop
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= S_BOOT;
            op_reg <= OP_INIT;
            idx_reg <= FIRST_IDX;
            withdraw_reg <= 1'b0;
            read_done_reg <= 1'b0;
            boot_reg <= 1'b1;
            cnt_reg <= CNT_ZERO;
            cmd_ready_reg <= 1'b0;
            pins_reg <= PINS_IDLE;
            dq_out_reg <= DATA_ZERO;
            dq_oe_n_reg <= 1'b1;
        end
        else
        begin
            unique case (state_reg)
                // Free every flag from this side; device reset is not trusted
                S_BOOT:
                begin
                    pins_reg.sem_n <= 1'b0;
                    pins_reg.rw_n <= 1'b0;
                    pins_reg.addr <= FIRST_IDX;
                    dq_out_reg <= DATA_ONES;
                    dq_oe_n_reg <= 1'b0;
                    idx_reg <= FIRST_IDX;
                    cnt_reg <= WR_CYC - 4'h1;
                    state_reg <= S_WRITE;
                end
                // Wait for a command
                S_IDLE:
                begin
                    if (cmd_valid && cmd_ready_reg)
                    begin
                        cmd_ready_reg <= 1'b0;
                        op_reg <= cmd.op;
                        withdraw_reg <= cmd.withdraw;
                        read_done_reg <= 1'b0;
                        boot_reg <= 1'b0;
                        pins_reg.addr <= (cmd.op == OP_INIT) ? FIRST_IDX : cmd.index;
                        idx_reg <= (cmd.op == OP_INIT) ? FIRST_IDX : cmd.index;
                        cnt_reg <= (cmd.op == OP_POLL) ? RD_CYC - 4'h1 : WR_CYC - 4'h1;
                        pins_reg.sem_n <= 1'b0;
                        if (cmd.op == OP_POLL)
                        begin
                            pins_reg.oe_n <= 1'b0;
                            state_reg <= S_READ;
                        end
                        else
                        begin
                            // Acquire writes zero first, never reads first
                            pins_reg.rw_n <= 1'b0;
                            dq_out_reg <= (cmd.op == OP_ACQUIRE) ? DATA_ZERO : DATA_ONES;
                            dq_oe_n_reg <= 1'b0;
                            state_reg <= S_WRITE;
                        end
                    end
                end
                // Write strobe held for the full width
                S_WRITE:
                begin
                    if (cnt_reg != CNT_ZERO)
                        cnt_reg <= cnt_reg - 4'h1;
                    else
                    begin
                        pins_reg.sem_n <= 1'b1;
                        pins_reg.rw_n <= 1'b1;
                        cnt_reg <= GAP_CYC - 4'h1;
                        state_reg <= S_WGAP;
                    end
                end
                // Data held past the strobe, then released
                S_WGAP:
                begin
                    if (cnt_reg != CNT_ZERO)
                        cnt_reg <= cnt_reg - 4'h1;
                    else if (op_reg == OP_INIT && idx_reg != LAST_IDX)
                    begin
                        // Next flag of the freeing sweep
                        idx_reg <= idx_reg + 3'h1;
                        pins_reg.addr <= idx_reg + 3'h1;
                        pins_reg.sem_n <= 1'b0;
                        pins_reg.rw_n <= 1'b0;
                        cnt_reg <= WR_CYC - 4'h1;
                        state_reg <= S_WRITE;
                    end
                    else if (op_reg == OP_ACQUIRE && !read_done_reg)
                    begin
                        // Read back the request just written
                        dq_oe_n_reg <= 1'b1;
                        pins_reg.sem_n <= 1'b0;
                        pins_reg.oe_n <= 1'b0;
                        cnt_reg <= RD_CYC - 4'h1;
                        state_reg <= S_READ;
                    end
                    else
                    begin
                        dq_oe_n_reg <= 1'b1;
                        cmd_ready_reg <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                // Read access; sample at the end of the window
                S_READ:
                begin
                    if (cnt_reg != CNT_ZERO)
                        cnt_reg <= cnt_reg - 4'h1;
                    else
                    begin
                        // Both go inactive so the next poll latches afresh
                        pins_reg.sem_n <= 1'b1;
                        pins_reg.oe_n <= 1'b1;
                        read_done_reg <= 1'b1;
                        cnt_reg <= GAP_CYC - 4'h1;
                        state_reg <= S_RGAP;
                    end
                end
                // Gap after a read; a failed acquire may withdraw
                S_RGAP:
                begin
                    if (cnt_reg != CNT_ZERO)
                        cnt_reg <= cnt_reg - 4'h1;
                    else if (op_reg == OP_ACQUIRE && withdraw_reg && rd_data_reg[0])
                    begin
                        // Leaving a zero pending could grant an unwanted token later
                        withdraw_reg <= 1'b0;
                        dq_out_reg <= DATA_ONES;
                        dq_oe_n_reg <= 1'b0;
                        pins_reg.sem_n <= 1'b0;
                        pins_reg.rw_n <= 1'b0;
                        cnt_reg <= WR_CYC - 4'h1;
                        state_reg <= S_WRITE;
                    end
                    else
                    begin
                        cmd_ready_reg <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Read capture
    // ---------------------------------------------------------------
    // Sampled on the last cycle of the read window
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rd_data_reg <= DATA_ONES;
        else if (state_reg == S_READ && cnt_reg == CNT_ZERO)
            rd_data_reg <= dq_in;
    end

    // ---------------------------------------------------------------
    // Response and status
    // ---------------------------------------------------------------
    // One strobe per user command as it returns to idle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rsp_valid_reg <= 1'b0;
            rsp_reg <= '0;
            init_done_reg <= 1'b0;
        end
        else
        begin
            rsp_valid_reg <= 1'b0;
            if (state_reg != S_IDLE && state_reg != S_BOOT && cmd_ready_reg == 1'b0
                && ((state_reg == S_WGAP && cnt_reg == CNT_ZERO
                     && !(op_reg == OP_INIT && idx_reg != LAST_IDX)
                     && !(op_reg == OP_ACQUIRE && !read_done_reg))
                    || (state_reg == S_RGAP && cnt_reg == CNT_ZERO
                        && !(op_reg == OP_ACQUIRE && withdraw_reg && rd_data_reg[0]))))
            begin
                if (boot_reg)
                    init_done_reg <= 1'b1;
                else
                begin
                    rsp_valid_reg <= 1'b1;
                    // A one on read back means the other side holds the token
                    rsp_reg.granted <= (op_reg == OP_ACQUIRE) && !rd_data_reg[0];
                    rsp_reg.flag <= (op_reg == OP_RELEASE || op_reg == OP_INIT) ? 1'b1 : rd_data_reg[0];
                    rsp_reg.spread_err <= (op_reg == OP_RELEASE || op_reg == OP_INIT) ? 1'b0
                                          : spread_bad(rd_data_reg);
                end
            end
        end
    end

    assign cmd_ready = cmd_ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp = rsp_reg;
    assign init_done = init_done_reg;
    assign pins = pins_reg;
    assign dq_out = dq_out_reg;
    assign dq_oe_n = dq_oe_n_reg;

endmodule // sem_port_ctrl
